// ===== hw/nvm_params.svh
// offsets, field positions, reset values and timing counts of the data eeprom control block
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// register indices; byte address is four times the index
`define NVM_IDX_MASK        12'hFA0
`define NVM_IDX_FLAG        12'hFA1
`define NVM_IDX_CTRL        12'hFA6
`define NVM_IDX_KEY         12'hFA7
`define NVM_IDX_DATA        12'hFA8
`define NVM_IDX_ADDR_LOW    12'hFA9
`define NVM_IDX_ADDR_HIGH   12'hFAA

// control register field positions
`define NVM_BIT_PGD         7
`define NVM_BIT_CSEL        6
`define NVM_BIT_FREE        4
`define NVM_BIT_ABORT       3
`define NVM_BIT_ALLOW       2
`define NVM_BIT_WR          1
`define NVM_BIT_RD          0

// peripheral flag and mask field position
`define NVM_BIT_DONE        0

// array geometry
`define NVM_DEPTH           1024
`define NVM_ADDR_W          10
`define NVM_HIGH_W          2

// unlock key values and erased cell value
`define NVM_KEY_FIRST       8'h55
`define NVM_KEY_SECOND      8'hAA
`define NVM_ERASED          8'hFF

// reset values
`define NVM_RESET_BYTE      8'h00
`define NVM_RESET_WORD      32'h0000_0000

// self-timed write length
`define NVM_WRITE_TIME_NS   4000
`define NVM_CLK_PERIOD_NS   4
`define NVM_WRITE_CYCLES    ((`NVM_WRITE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)

`endif

// ===== hw/nvm_pkg.sv
// types shared by the data eeprom control block
package nvm_pkg;

    typedef enum logic [1:0] {
        key_idle,
        key_first,
        key_armed
    } unlock_state_type;

    typedef struct packed {
        logic program_space_select;
        logic config_space_select;
        logic row_erase_select;
        logic write_abort_flag;
        logic write_allow;
        logic write_trigger;
        logic read_trigger;
    } nvm_control_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
        logic        resp_valid;
    } apb_resp_type;

    typedef struct packed {
        nvm_control_type  ctl;
        logic [1:0]       addr_high;
        logic [7:0]       addr_low;
        logic [7:0]       data;
        unlock_state_type unlock;
        logic             write_done_flag;
        logic             write_done_mask;
        logic             ext_meta;
        logic             ext_sync;
        logic             watchdog_meta;
        logic             watchdog_sync;
        apb_resp_type     rsp;
    } ctrl_state_type;

endpackage : nvm_pkg

// ===== hw/nvm_write_timer.sv
// self-timed write counter
`include "nvm_params.svh"

module nvm_write_timer
    import nvm_pkg::*;
#(
    parameter int write_cycles = `NVM_WRITE_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic abort,
    output logic      busy,
    output logic      done
);

    localparam int cw = $clog2(write_cycles + 1);

    typedef struct packed {
        logic          busy;
        logic [cw-1:0] count;
    } timer_state_type;

    timer_state_type state;
    timer_state_type next_state;

    assign busy = state.busy;
    assign done = state.busy && (state.count == cw'(write_cycles - 1)) && !abort;

    always_comb begin
        next_state = state;
        if (abort) begin
            next_state = '0;
        end else if (start && !state.busy) begin
            next_state.busy  = 1'b1;
            next_state.count = '0;
        end else if (done) begin
            next_state = '0;
        end else if (state.busy) begin
            next_state.count = state.count + cw'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : nvm_write_timer

// ===== hw/nvm_cell_array.sv
// data eeprom cell array, asynchronous read and clocked byte write
`include "nvm_params.svh"

module nvm_cell_array
    import nvm_pkg::*;
#(
    parameter int depth  = `NVM_DEPTH,
    parameter int addr_w = `NVM_ADDR_W
) (
    input  wire logic              mclk,
    input  wire logic              write_en,
    input  wire logic [addr_w-1:0] addr,
    input  wire logic [7:0]        write_data,
    output logic      [7:0]        read_data
);

    logic [7:0] cells [depth];

    assign read_data = cells[addr];

    always_ff @(posedge mclk) begin
        if (write_en) begin
            cells[addr] <= write_data;
        end
    end

endmodule : nvm_cell_array

// ===== hw/data_eeprom_control_regs.sv
// data eeprom control, address and unlock registers behind an apb slave
//
// Functional notes
// - ten-bit byte address from the register pair reaches 1024 locations.
// - high register holds address bits nine and eight, low register bits seven to zero.
// - upper six bits of the high address register ignore writes, read zero.
// - unlock key port stores nothing, reads zero, serves only the unlock sequence.
// - write starts only after 55h, then AAh to the key, then write trigger.
// - software may set read and write triggers but cannot clear them.
// - hardware clears each trigger when its read or write has finished.
// - write allow is clear after power-up; writes need it held set.
// - write trigger is blocked unless write allow was already set.
// - pin or watchdog reset during a self-timed write sets the abort flag.
// - abort flag at one means a reset-cut write or an improper attempt.
// - the aborting reset forces data and address registers to zero.
// - write completion sets the done flag; only software clears it.
// - control register bit order: space, config, unused, row erase, abort, allow, write, read.
// - only with both space selects clear is the data eeprom the target.
// - a read places the addressed byte in the data register within one cycle.
`include "nvm_params.svh"

module data_eeprom_control_regs
    import nvm_pkg::*;
#(
    parameter int write_cycles = `NVM_WRITE_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ext_reset_n,
    input  wire logic        watchdog_timeout,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    ctrl_state_type state;
    ctrl_state_type next_state;

    logic [11:0]            idx;
    logic                   addr_ok;
    logic                   access;
    logic                   wr_hit;
    logic                   aligned;
    logic                   in_window;
    logic                   ctrl_wr;
    logic                   launch_ok;
    logic [7:0]             wbyte;
    logic [7:0]             rd_byte;
    logic                   warm;
    logic                   busy;
    logic                   timer_done;
    logic                   start_write;
    logic                   improper;
    logic                   mem_we;
    logic [7:0]             mem_wdata;
    logic [7:0]             mem_rdata;
    logic [`NVM_ADDR_W-1:0] mem_addr;

    function automatic logic [11:0] reg_index(input logic [31:0] addr);
        return addr[13:2];
    endfunction : reg_index

    function automatic logic index_mapped(input logic [11:0] i);
        case (i)
            `NVM_IDX_MASK,
            `NVM_IDX_FLAG,
            `NVM_IDX_CTRL,
            `NVM_IDX_KEY,
            `NVM_IDX_DATA,
            `NVM_IDX_ADDR_LOW,
            `NVM_IDX_ADDR_HIGH: return 1'b1;
            default:            return 1'b0;
        endcase
    endfunction : index_mapped

    function automatic logic data_target(input logic [7:0] b);
        return !b[`NVM_BIT_PGD] && !b[`NVM_BIT_CSEL];
    endfunction : data_target

    function automatic logic [7:0] flag_byte(input logic bit_value);
        logic [7:0] b;
        b = `NVM_RESET_BYTE;
        b[`NVM_BIT_DONE] = bit_value;
        return b;
    endfunction : flag_byte

    function automatic logic [7:0] control_byte(input nvm_control_type c);
        logic [7:0] b;
        b = `NVM_RESET_BYTE;
        b[`NVM_BIT_PGD]   = c.program_space_select;
        b[`NVM_BIT_CSEL]  = c.config_space_select;
        b[`NVM_BIT_FREE]  = c.row_erase_select;
        b[`NVM_BIT_ABORT] = c.write_abort_flag;
        b[`NVM_BIT_ALLOW] = c.write_allow;
        b[`NVM_BIT_WR]    = c.write_trigger;
        b[`NVM_BIT_RD]    = c.read_trigger;
        return b;
    endfunction : control_byte

    // bus decode
    assign idx     = reg_index(paddr);
    assign aligned   = (paddr[1:0] == 2'h0);
    assign in_window = (paddr[31:14] == 18'h0);
    assign addr_ok   = aligned && in_window && index_mapped(idx);
    assign access  = psel && penable && state.rsp.resp_valid;
    assign wbyte   = pwdata[7:0];
    assign wr_hit  = access && pwrite && pstrb[0] && addr_ok && !warm;

    // outputs
    assign pready  = access;
    assign prdata  = state.rsp.prdata;
    assign pslverr = state.rsp.pslverr;
    assign irq     = state.write_done_flag && state.write_done_mask;

    // pin and watchdog resets after two flops
    assign warm = state.ext_sync || state.watchdog_sync;

    assign mem_addr = {state.addr_high, state.addr_low};

    // control write asking for a write launch
    assign ctrl_wr   = wr_hit && (idx == `NVM_IDX_CTRL);
    assign launch_ok = ctrl_wr && !busy
                       && wbyte[`NVM_BIT_WR]
                       && state.ctl.write_allow
                       && data_target(wbyte);

    // write launch needs the armed key, write allow already set, data target
    assign start_write = launch_ok && (state.unlock == key_armed);

    // trigger write with allow set but key sequence not done
    assign improper = launch_ok && (state.unlock != key_armed);

    // erase at launch, program at completion
    assign mem_we    = start_write || timer_done;
    assign mem_wdata = start_write ? `NVM_ERASED : state.data;

    nvm_write_timer #(
        .write_cycles (write_cycles)
    ) u_timer (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (start_write),
        .abort (warm),
        .busy  (busy),
        .done  (timer_done)
    );

    nvm_cell_array #(
        .depth  (`NVM_DEPTH),
        .addr_w (`NVM_ADDR_W)
    ) u_cells (
        .mclk       (mclk),
        .write_en   (mem_we),
        .addr       (mem_addr),
        .write_data (mem_wdata),
        .read_data  (mem_rdata)
    );

    // register read mux
    always_comb begin
        rd_byte = `NVM_RESET_BYTE;
        case (idx)
            `NVM_IDX_CTRL: begin
                rd_byte = control_byte(state.ctl);
            end
            `NVM_IDX_KEY: begin
                rd_byte = `NVM_RESET_BYTE;
            end
            `NVM_IDX_DATA: begin
                rd_byte = state.data;
            end
            `NVM_IDX_ADDR_LOW: begin
                rd_byte = state.addr_low;
            end
            `NVM_IDX_ADDR_HIGH: begin
                rd_byte = {6'h00, state.addr_high};
            end
            `NVM_IDX_FLAG: begin
                rd_byte = flag_byte(state.write_done_flag);
            end
            `NVM_IDX_MASK: begin
                rd_byte = flag_byte(state.write_done_mask);
            end
            default: begin
                rd_byte = `NVM_RESET_BYTE;
            end
        endcase
    end

    always_comb begin
        next_state = state;

        // two-flop synchronisers, asserted level stored high
        next_state.ext_meta = !ext_reset_n;
        next_state.ext_sync = state.ext_meta;
        next_state.watchdog_meta = watchdog_timeout;
        next_state.watchdog_sync = state.watchdog_meta;

        // apb answer: one wait cycle, data latched in first access cycle
        if (psel && penable && !state.rsp.resp_valid) begin
            next_state.rsp.resp_valid = 1'b1;
            next_state.rsp.pslverr    = !addr_ok;
            next_state.rsp.prdata     = `NVM_RESET_WORD;
            if (!pwrite && addr_ok) begin
                next_state.rsp.prdata = {24'h000000, rd_byte};
            end
        end else if (access) begin
            next_state.rsp.resp_valid = 1'b0;
        end

        // read completes one cycle after the trigger is set
        if (state.ctl.read_trigger) begin
            if (!state.ctl.config_space_select) begin
                next_state.data = mem_rdata;
            end
            next_state.ctl.read_trigger = 1'b0;
        end

        // software writes
        if (wr_hit) begin
            if (idx != `NVM_IDX_KEY) begin
                next_state.unlock = key_idle;
            end
            case (idx)
                `NVM_IDX_CTRL: begin
                    if (!busy) begin
                        next_state.ctl.program_space_select = wbyte[`NVM_BIT_PGD];
                        next_state.ctl.config_space_select  = wbyte[`NVM_BIT_CSEL];
                        next_state.ctl.row_erase_select     = wbyte[`NVM_BIT_FREE];
                        next_state.ctl.write_abort_flag     = wbyte[`NVM_BIT_ABORT];
                        next_state.ctl.write_allow          = wbyte[`NVM_BIT_ALLOW];
                        if (wbyte[`NVM_BIT_RD] && !wbyte[`NVM_BIT_PGD] && !start_write) begin
                            next_state.ctl.read_trigger = 1'b1;
                        end
                        if (start_write) begin
                            next_state.ctl.write_trigger = 1'b1;
                        end
                    end
                end
                `NVM_IDX_KEY: begin
                    if (!busy) begin
                        case (state.unlock)
                            key_idle: begin
                                if (wbyte == `NVM_KEY_FIRST) begin
                                    next_state.unlock = key_first;
                                end else begin
                                    next_state.unlock = key_idle;
                                end
                            end
                            key_first: begin
                                if (wbyte == `NVM_KEY_SECOND) begin
                                    next_state.unlock = key_armed;
                                end else if (wbyte == `NVM_KEY_FIRST) begin
                                    next_state.unlock = key_first;
                                end else begin
                                    next_state.unlock = key_idle;
                                end
                            end
                            key_armed: begin
                                if (wbyte == `NVM_KEY_FIRST) begin
                                    next_state.unlock = key_first;
                                end else begin
                                    next_state.unlock = key_idle;
                                end
                            end
                            default: begin
                                next_state.unlock = key_idle;
                            end
                        endcase
                    end
                end
                `NVM_IDX_DATA: begin
                    if (!busy) begin
                        next_state.data = wbyte;
                    end
                end
                `NVM_IDX_ADDR_LOW: begin
                    if (!busy) begin
                        next_state.addr_low = wbyte;
                    end
                end
                `NVM_IDX_ADDR_HIGH: begin
                    if (!busy) begin
                        next_state.addr_high = wbyte[`NVM_HIGH_W-1:0];
                    end
                end
                `NVM_IDX_FLAG: begin
                    if (wbyte[`NVM_BIT_DONE]) begin
                        next_state.write_done_flag = 1'b0;
                    end
                end
                `NVM_IDX_MASK: begin
                    next_state.write_done_mask = wbyte[`NVM_BIT_DONE];
                end
                default: begin
                end
            endcase
        end

        // hardware sets win over software clears
        if (improper) begin
            next_state.ctl.write_abort_flag = 1'b1;
        end
        if (timer_done) begin
            next_state.ctl.write_trigger = 1'b0;
            next_state.write_done_flag   = 1'b1;
        end

        // pin or watchdog reset: clear all but abort flag and interrupt state
        if (warm) begin
            next_state.ctl.program_space_select = 1'b0;
            next_state.ctl.config_space_select  = 1'b0;
            next_state.ctl.row_erase_select     = 1'b0;
            next_state.ctl.write_allow          = 1'b0;
            next_state.ctl.write_trigger        = 1'b0;
            next_state.ctl.read_trigger         = 1'b0;
            if (busy) begin
                next_state.ctl.write_abort_flag = 1'b1;
            end
            next_state.addr_high = '0;
            next_state.addr_low  = `NVM_RESET_BYTE;
            next_state.data      = `NVM_RESET_BYTE;
            next_state.unlock    = key_idle;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : data_eeprom_control_regs

// ===== verif/data_eeprom_control_regs_monitor.sv
// concurrent checks on the ports of the data eeprom control block
module data_eeprom_control_regs_monitor
    import nvm_pkg::*;
#(
    parameter int write_cycles = 4
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        ext_reset_n,
    input wire logic        watchdog_timeout,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_ack;
    assign rd_ack = pready && !pwrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_ready_qual;
        pready |-> psel && penable;
    endproperty
    a_ready_qual: assert property (p_ready_qual) else $error("ready outside access");
    property p_one_wait;
        psel && !penable ##1 psel && penable |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("access not one wait");
    property p_upper_zero;
        rd_ack |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read upper bits set");
    property p_key_zero;
        rd_ack && paddr == 32'h0000_3E9C |-> prdata == 32'h0000_0000;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key port not zero");
    property p_high_zero;
        rd_ack && paddr == 32'h0000_3EA8 |-> prdata[7:2] == 6'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high addr upper bits");
    property p_ctrl_bits;
        rd_ack && paddr == 32'h0000_3E98 |-> !prdata[5] && !prdata[0];
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("control bits wrong");
    property p_far_err;
        pready && paddr[31:14] != 18'h00000 |-> pslverr;
    endproperty
    a_far_err: assert property (p_far_err) else $error("far address accepted");
    property p_irq_sticky;
        irq && !(pready && pwrite) |=> irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped alone");
endmodule : data_eeprom_control_regs_monitor

bind data_eeprom_control_regs data_eeprom_control_regs_monitor #(.write_cycles(write_cycles))
    data_eeprom_control_regs_monitor_i (.mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .watchdog_timeout(watchdog_timeout), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));

// ===== verif/data_eeprom_control_regs_tb.sv
// self-checking bench for the data eeprom control block
module data_eeprom_control_regs_tb
    import nvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] a_mask = 32'h0000_3E80;
    localparam logic [31:0] a_flag = 32'h0000_3E84;
    localparam logic [31:0] a_ctrl = 32'h0000_3E98;
    localparam logic [31:0] a_key  = 32'h0000_3E9C;
    localparam logic [31:0] a_data = 32'h0000_3EA0;
    localparam logic [31:0] a_low  = 32'h0000_3EA4;
    localparam logic [31:0] a_high = 32'h0000_3EA8;
    logic        mclk, rst_n, ext_reset_n, watchdog_timeout, psel, penable, pwrite;
    logic        pready, pslverr, irq, rerr;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    int          mismatches, tests_run;

    data_eeprom_control_regs #(.write_cycles(8)) data_eeprom_control_regs_i (
        .mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .watchdog_timeout(watchdog_timeout),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            mismatches++;
            report_and_stop();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] addr, input logic [7:0] val);
        apb(1'b1, addr, {24'h000000, val});
    endtask : wr

    task automatic expect_rd(input string what, input logic [31:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(what, {24'h000000, exp}, rdata);
        check({what, " err"}, 32'h0000_0000, {31'h0, rerr});
    endtask : expect_rd

    task automatic expect_irq(input logic exp);
        @(posedge mclk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask : expect_irq

    task automatic start_write(input logic [9:0] addr, input logic [7:0] val);
        wr(a_high, {6'h00, addr[9:8]});
        wr(a_low, addr[7:0]);
        wr(a_data, val);
        wr(a_ctrl, 8'h04);
        wr(a_key, 8'h55);
        wr(a_key, 8'hAA);
        wr(a_ctrl, 8'h06);
    endtask : start_write

    task automatic wait_idle();
        int n;
        for (n = 0; n < 8; n++) begin
            apb(1'b0, a_ctrl, 32'h0000_0000);
            if (rdata[1] === 1'b0) break;
        end
        check("write trigger", 32'h0000_0000, {31'h0, rdata[1]});
        if (n == 8) begin
            report_and_stop();
        end
    endtask : wait_idle

    task automatic t_reset();
        expect_rd("ctrl at reset", a_ctrl, 8'h00);
        expect_rd("low at reset", a_low, 8'h00);
        expect_rd("data at reset", a_data, 8'h00);
        expect_rd("flag at reset", a_flag, 8'h00);
    endtask : t_reset

    task automatic t_addr();
        wr(a_high, 8'hFF);
        expect_rd("addr high", a_high, 8'h03);
        wr(a_low, 8'h5A);
        expect_rd("addr low", a_low, 8'h5A);
        pstrb <= 4'h0;
        wr(a_low, 8'hA5);
        pstrb <= 4'hF;
        expect_rd("strobe off", a_low, 8'h5A);
        wr(a_key, 8'h55);
        expect_rd("key port", a_key, 8'h00);
        apb(1'b0, 32'h0000_3E88, 32'h0000_0000);
        check("unmapped err", 32'h0000_0001, {31'h0, rerr});
        apb(1'b0, 32'h0001_3E98, 32'h0000_0000);
        check("far err", 32'h0000_0001, {31'h0, rerr});
    endtask : t_addr

    task automatic t_write();
        wr(a_ctrl, 8'h06);
        expect_rd("allow and trigger", a_ctrl, 8'h04);
        start_write(10'h3FF, 8'hC3);
        expect_rd("trigger held", a_ctrl, 8'h06);
        wait_idle();
        expect_rd("done flag", a_flag, 8'h01);
        expect_irq(1'b0);
        wr(a_mask, 8'h01);
        expect_irq(1'b1);
        wr(a_flag, 8'h01);
        expect_irq(1'b0);
        wr(a_data, 8'h00);
        wr(a_ctrl, 8'h05);
        expect_rd("read back", a_data, 8'hC3);
        expect_rd("read trigger", a_ctrl, 8'h04);
    endtask : t_write

    task automatic t_improper();
        wr(a_key, 8'hAA);
        wr(a_key, 8'h55);
        wr(a_ctrl, 8'h06);
        expect_rd("abort flag", a_ctrl, 8'h0C);
        wr(a_ctrl, 8'h85);
        expect_rd("space select", a_ctrl, 8'h84);
        wr(a_ctrl, 8'h00);
    endtask : t_improper

    task automatic t_warm(input logic by_pin);
        start_write(10'h155, 8'h3C);
        ext_reset_n <= !by_pin;
        watchdog_timeout <= !by_pin;
        repeat (4) @(posedge mclk);
        ext_reset_n <= 1'b1;
        watchdog_timeout <= 1'b0;
        repeat (4) @(posedge mclk);
        expect_rd("warm ctrl", a_ctrl, 8'h08);
        expect_rd("warm low", a_low, 8'h00);
        expect_rd("warm high", a_high, 8'h00);
        expect_rd("warm data", a_data, 8'h00);
        expect_rd("warm flag", a_flag, 8'h00);
        wr(a_ctrl, 8'h00);
        start_write(10'h155, 8'h3C);
        wait_idle();
        expect_rd("rewrite flag", a_flag, 8'h01);
        wr(a_flag, 8'h01);
    endtask : t_warm

    initial begin
        rst_n       = 1'b0;
        ext_reset_n = 1'b1;
        watchdog_timeout = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 32'h0000_0000;
        pwdata      = 32'h0000_0000;
        pstrb       = 4'hF;
        mismatches  = 0;
        tests_run   = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_addr();
        t_write();
        t_improper();
        t_warm(1'b1);
        t_warm(1'b0);
        report_and_stop();
    end
endmodule : data_eeprom_control_regs_tb
